//--- hdl/rxom_defs.vh
`ifndef RXOM_DEFS_VH
`define RXOM_DEFS_VH

// ****************************************************************
// bus and address layout
// ****************************************************************
`define RXOM_AW            14
`define RXOM_DW            8
`define RXOM_OFS_W         9
`define RXOM_PORT_STRIDE   14'h0200
`define RXOM_GROUP_STRIDE  14'h2000
`define RXOM_GROUP_SHIFT   3

// ****************************************************************
// register offsets inside one port window
// ****************************************************************
`define RXOM_OFS_FE_A_HIGH 9'h058
`define RXOM_OFS_FE_A_LOW  9'h059
`define RXOM_OFS_FE_B_HIGH 9'h05A
`define RXOM_OFS_FE_B_LOW  9'h05B
`define RXOM_OFS_MON_BYTE  9'h060
`define RXOM_OFS_DL_BYTE   9'h062
`define RXOM_OFS_BOC       9'h063
`define RXOM_OFS_CAP_ONE   9'h064
`define RXOM_OFS_CAP_TWO   9'h065
`define RXOM_OFS_CAP_THREE 9'h066
`define RXOM_OFS_CTRL      9'h07F

// ****************************************************************
// control register fields
// ****************************************************************
`define RXOM_CTRL_E1       0
`define RXOM_CTRL_D4       1
`define RXOM_CTRL_SLC      2
`define RXOM_CTRL_CRC4     3
`define RXOM_CTRL_W        4
`define RXOM_CTRL_RST      4'h0

// ****************************************************************
// widths, counts and reset values
// ****************************************************************
`define RXOM_FE_CNT_W      16
`define RXOM_FE_CNT_MAX    16'hFFFF
`define RXOM_CSC_W         6
`define RXOM_CSC_MAX       6'h3F
`define RXOM_BOC_W         6
`define RXOM_SLC_W         24
`define RXOM_FDL_LAST      3'h7
`define RXOM_BYTE_RST      8'h00
`define RXOM_SLC_RST       24'h000000
`define RXOM_ZERO8         8'h00
`define RXOM_ZERO2         2'h0

`endif

//--- hdl/rxom_event_counter.v
`timescale 1ns/1ps
`default_nettype none
`include "rxom_defs.vh"

// ****************************************************************
// saturating event counter
// ****************************************************************
module rxom_event_counter (
  input  wire                      ref_clk_i,
  input  wire                      reset_i,
  input  wire                      ce_i,
  input  wire                      event_i,
  output wire [`RXOM_FE_CNT_W-1:0] count_o
);

  reg  [`RXOM_FE_CNT_W-1:0] count_reg;
  wire [`RXOM_FE_CNT_W-1:0] count_next;

  // holding at full scale keeps a long error burst from reading as few
  assign count_next = (count_reg == `RXOM_FE_CNT_MAX) ? count_reg :
                      count_reg + 16'h0001;

  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      count_reg <= 16'h0000;
    end else if (ce_i && event_i) begin
      count_reg <= count_next;
    end
  end

  assign count_o = count_reg;

endmodule // rxom_event_counter

`default_nettype wire

//--- hdl/rxom_overhead_monitor.v
// Notes on behaviour
// RULE_01: 16-bit far-end error A count, high byte then low byte.
// RULE_02: 16-bit far-end error B count, high then low byte, reset zero.
// RULE_03: monitor byte holds selected timeslot, first bit in bit 7.
// RULE_04: T1 data link byte reports FDL or Fs bits, first bit LSB.
// RULE_05: data link code MSB in bit 7, earliest received bit is LSB.
// RULE_06: D4 data link updates at multiframe end, six Fs bits in 5:0.
// RULE_07: in E1 mode data link address returns live sync status.
// RULE_08: E1 sync status bits are live, never latched.
// RULE_09: CRC-4 sync counter increments on each failed 8 ms search.
// RULE_10: sync counter clears on CRC-4 sync or CRC-4 enable at zero.
// RULE_11: 6-bit saturating counter, bits 5,4,3,2,0 shown in 7:3.
// RULE_12: software should abandon CRC-4 search after 400 ms.
// RULE_13: status bit 2 high while hunting CRC-4 multiframe word.
// RULE_14: bit 1 high hunting signaling multiframe, bit 0 hunting FAS.
// RULE_15: bit-oriented code register keeps last valid code in 5:0.
// RULE_16: SLC-96 data link captured in three consecutive registers.
// RULE_17: E1 first capture address holds align frame timeslot 0 byte.
// RULE_18: E1 second address holds the non-align frame byte.
// RULE_19: E1 third address collects Si bits of even align frames.
// RULE_20: port window at 200h per port plus 2000h per group of 8.
// RULE_21: capture registers freeze while receive sync is lost.
// RULE_22: reads have no side effects on counters or captures.
`timescale 1ns/1ps
`default_nettype none
`include "rxom_defs.vh"

module rxom_overhead_monitor #(
  parameter [4:0] PORT_NUM = 5'd1
) (
  input  wire                    ref_clk_i,
  input  wire                    reset_i,
  input  wire                    ce_i,
  input  wire [`RXOM_AW-1:0]     addr_i,
  input  wire [`RXOM_DW-1:0]     wr_data_i,
  input  wire                    wr_en_i,
  input  wire                    rd_en_i,
  output wire [`RXOM_DW-1:0]     rd_data_o,
  input  wire                    rx_sync_lost_i,
  input  wire                    fe_err_a_evt_i,
  input  wire                    fe_err_b_evt_i,
  input  wire                    mon_bit_i,
  input  wire                    mon_bit_vld_i,
  input  wire                    mon_bit_last_i,
  input  wire                    dl_bit_i,
  input  wire                    dl_bit_vld_i,
  input  wire                    dl_mf_end_i,
  input  wire [`RXOM_BOC_W-1:0]  boc_code_i,
  input  wire                    boc_code_vld_i,
  input  wire [`RXOM_DW-1:0]     ts0_byte_i,
  input  wire                    ts0_vld_i,
  input  wire                    ts0_align_i,
  input  wire [3:0]              ts0_frame_i,
  input  wire                    crc_search_timeout_i,
  input  wire                    crc_sync_gained_i,
  input  wire                    crc_search_i,
  input  wire                    cas_search_i,
  input  wire                    fas_search_i
);

  // ****************************************************************
  // port window decode
  // ****************************************************************
  function [`RXOM_AW-1:0] port_base;
    input [4:0] num;
    reg   [3:0] idx;
    reg   [`RXOM_AW-1:0] stride_sum;
    reg   [`RXOM_AW-1:0] group_sum;
    begin
      idx        = num[3:0] - 4'h1;
      stride_sum = `RXOM_PORT_STRIDE * {10'h000, idx};
      group_sum  = `RXOM_GROUP_STRIDE *
                   {10'h000, idx >> `RXOM_GROUP_SHIFT};
      port_base  = stride_sum + group_sum;
    end
  endfunction

  localparam [`RXOM_AW-1:0] BASE = port_base(PORT_NUM); // [RULE_20]

  wire                   port_hit;
  wire [`RXOM_OFS_W-1:0] offset;

  // each window spans 200h, so the upper bits alone pick the port
  assign port_hit = (addr_i[`RXOM_AW-1:`RXOM_OFS_W] ==
                     BASE[`RXOM_AW-1:`RXOM_OFS_W]);  // [RULE_20]
  assign offset   = addr_i[`RXOM_OFS_W-1:0];

  // ****************************************************************
  // control register
  // ****************************************************************
  reg  [`RXOM_CTRL_W-1:0] ctrl_reg;
  wire                    e1_mode;
  wire                    d4_mode;
  wire                    slc_mode;
  wire                    crc4_en;
  wire                    hold_caps;

  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      ctrl_reg <= `RXOM_CTRL_RST;
    end else if (ce_i && wr_en_i && port_hit &&
                 offset == `RXOM_OFS_CTRL) begin
      ctrl_reg <= wr_data_i[`RXOM_CTRL_W-1:0];
    end
  end

  assign e1_mode   = ctrl_reg[`RXOM_CTRL_E1];
  assign d4_mode   = ctrl_reg[`RXOM_CTRL_D4] | ctrl_reg[`RXOM_CTRL_SLC];
  assign slc_mode  = ctrl_reg[`RXOM_CTRL_SLC];
  assign crc4_en   = ctrl_reg[`RXOM_CTRL_CRC4];
  assign hold_caps = rx_sync_lost_i;  // [RULE_21]

  // ****************************************************************
  // far-end error counters
  // ****************************************************************
  wire [`RXOM_FE_CNT_W-1:0] fe_a_count;
  wire [`RXOM_FE_CNT_W-1:0] fe_b_count;

  rxom_event_counter u_fe_a_cnt (  // [RULE_01]
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .ce_i      (ce_i),
    .event_i   (fe_err_a_evt_i),
    .count_o   (fe_a_count)
  );

  rxom_event_counter u_fe_b_cnt (  // [RULE_02]
    .ref_clk_i (ref_clk_i),
    .reset_i   (reset_i),
    .ce_i      (ce_i),
    .event_i   (fe_err_b_evt_i),
    .count_o   (fe_b_count)
  );

  // ****************************************************************
  // timeslot monitor byte
  // ****************************************************************
  reg  [`RXOM_DW-1:0] mon_shift_reg;
  reg  [`RXOM_DW-1:0] mon_byte_reg;
  wire [`RXOM_DW-1:0] mon_shift_next;

  // shift left so the first bit of the slot ends in bit 7
  assign mon_shift_next = {mon_shift_reg[`RXOM_DW-2:0], mon_bit_i};

  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      mon_shift_reg <= `RXOM_BYTE_RST;
      mon_byte_reg  <= `RXOM_BYTE_RST;
    end else if (ce_i && mon_bit_vld_i) begin
      mon_shift_reg <= mon_shift_next;  // [RULE_03]
      if (mon_bit_last_i && !hold_caps) begin
        mon_byte_reg <= mon_shift_next;  // [RULE_03] [RULE_21]
      end
    end
  end

  // ****************************************************************
  // T1 data link: FDL bytes, D4 Fs bits and SLC-96 word
  // ****************************************************************
  reg  [`RXOM_DW-1:0]    dl_shift_reg;
  reg  [2:0]             dl_cnt_reg;
  reg  [`RXOM_DW-1:0]    dl_byte_reg;
  reg  [`RXOM_SLC_W-1:0] slc_shift_reg;
  reg  [`RXOM_SLC_W-1:0] slc_word_reg;
  wire [`RXOM_DW-1:0]    dl_shift_next;
  wire [`RXOM_SLC_W-1:0] slc_shift_next;

  // shift right so the earliest bit settles in the LSB
  assign dl_shift_next  = {dl_bit_i, dl_shift_reg[`RXOM_DW-1:1]};
  assign slc_shift_next = {dl_bit_i, slc_shift_reg[`RXOM_SLC_W-1:1]};

  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      dl_shift_reg  <= `RXOM_BYTE_RST;
      dl_cnt_reg    <= 3'h0;
      dl_byte_reg   <= `RXOM_BYTE_RST;
      slc_shift_reg <= `RXOM_SLC_RST;
      slc_word_reg  <= `RXOM_SLC_RST;
    end else if (ce_i && !e1_mode) begin
      if (d4_mode) begin
        if (dl_mf_end_i) begin
          // boundary bit is the last Fs bit of the superframe
          if (!hold_caps) begin
            dl_byte_reg <= {`RXOM_ZERO2,
                            dl_shift_next[`RXOM_DW-1:2]};  // [RULE_06]
          end
          if (slc_mode && !hold_caps) begin
            slc_word_reg <= slc_shift_next;  // [RULE_16] [RULE_21]
          end
          dl_shift_reg  <= `RXOM_BYTE_RST;
          slc_shift_reg <= `RXOM_SLC_RST;
        end else if (dl_bit_vld_i) begin
          dl_shift_reg  <= dl_shift_next;
          slc_shift_reg <= slc_shift_next;  // [RULE_16]
        end
      end else if (dl_bit_vld_i) begin
        dl_shift_reg <= dl_shift_next;  // [RULE_04]
        dl_cnt_reg   <= dl_cnt_reg + 3'h1;
        if (dl_cnt_reg == `RXOM_FDL_LAST && !hold_caps) begin
          dl_byte_reg <= dl_shift_next;  // [RULE_05] [RULE_21]
        end
      end
    end
  end

  // ****************************************************************
  // bit-oriented code
  // ****************************************************************
  reg [`RXOM_BOC_W-1:0] boc_reg;

  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      boc_reg <= 6'h00;
    end else if (ce_i && boc_code_vld_i && !e1_mode && !hold_caps) begin
      boc_reg <= boc_code_i;  // [RULE_15] [RULE_21]
    end
  end

  // ****************************************************************
  // E1 timeslot 0 captures
  // ****************************************************************
  reg [`RXOM_DW-1:0] align_byte_reg;
  reg [`RXOM_DW-1:0] nonalign_byte_reg;
  reg [`RXOM_DW-1:0] si_bits_reg;

  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      align_byte_reg    <= `RXOM_BYTE_RST;
      nonalign_byte_reg <= `RXOM_BYTE_RST;
      si_bits_reg       <= `RXOM_BYTE_RST;
    end else if (ce_i && e1_mode && ts0_vld_i && !hold_caps) begin
      if (ts0_align_i) begin
        align_byte_reg <= ts0_byte_i;  // [RULE_17] [RULE_21]
        // align frames sit in even frames; frame 14 lands in bit 7
        si_bits_reg[ts0_frame_i[3:1]] <= ts0_byte_i[7];  // [RULE_19]
      end else begin
        nonalign_byte_reg <= ts0_byte_i;  // [RULE_18]
      end
    end
  end

  // ****************************************************************
  // CRC-4 multiframe search counter
  // ****************************************************************
  reg  [`RXOM_CSC_W-1:0] csc_reg;
  wire [`RXOM_CSC_W-1:0] csc_next;

  assign csc_next = (csc_reg == `RXOM_CSC_MAX) ? csc_reg :
                    csc_reg + 6'h01;  // [RULE_11]

  // clearing outranks a timeout in the same cycle: sync was gained
  // software copes with the 400 ms give-up decision from this count
  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      csc_reg <= 6'h00;
    end else if (ce_i) begin
      if (crc_sync_gained_i || !crc4_en) begin
        csc_reg <= 6'h00;  // [RULE_10]
      end else if (crc_search_timeout_i) begin
        csc_reg <= csc_next;  // [RULE_09]
      end
    end
  end

  // ****************************************************************
  // register read port
  // ****************************************************************
  reg  [`RXOM_DW-1:0] rd_data_reg;
  reg  [`RXOM_DW-1:0] rd_mux;
  wire [`RXOM_DW-1:0] e1_status;

  // bit 1 of the count is dropped to stretch range past 400 ms
  assign e1_status = {csc_reg[5:2], csc_reg[0],     // [RULE_11]
                      crc_search_i,                 // [RULE_13]
                      cas_search_i, fas_search_i};  // [RULE_08] [RULE_14]

  always @* begin
    rd_mux = `RXOM_ZERO8;
    case (offset)
      `RXOM_OFS_FE_A_HIGH: rd_mux = fe_a_count[15:8];  // [RULE_01]
      `RXOM_OFS_FE_A_LOW:  rd_mux = fe_a_count[7:0];   // [RULE_01]
      `RXOM_OFS_FE_B_HIGH: rd_mux = fe_b_count[15:8];  // [RULE_02]
      `RXOM_OFS_FE_B_LOW:  rd_mux = fe_b_count[7:0];   // [RULE_02]
      `RXOM_OFS_MON_BYTE:  rd_mux = mon_byte_reg;
      `RXOM_OFS_DL_BYTE:
        rd_mux = e1_mode ? e1_status : dl_byte_reg;    // [RULE_07]
      `RXOM_OFS_BOC:
        rd_mux = e1_mode ? `RXOM_ZERO8 :
                 {`RXOM_ZERO2, boc_reg};               // [RULE_15]
      `RXOM_OFS_CAP_ONE:
        rd_mux = e1_mode ? align_byte_reg :
                 slc_word_reg[7:0];                    // [RULE_16]
      `RXOM_OFS_CAP_TWO:
        rd_mux = e1_mode ? nonalign_byte_reg :
                 slc_word_reg[15:8];                   // [RULE_16]
      `RXOM_OFS_CAP_THREE:
        rd_mux = e1_mode ? si_bits_reg :
                 slc_word_reg[23:16];                  // [RULE_16]
      `RXOM_OFS_CTRL:
        rd_mux = {4'h0, ctrl_reg};
      default: rd_mux = `RXOM_ZERO8;
    endcase
  end

  // reads only sample state; nothing is cleared on read
  // data stands for the single cycle after the strobe, zero otherwise
  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rd_data_reg <= `RXOM_ZERO8;
    end else if (ce_i) begin
      if (rd_en_i && port_hit) begin
        rd_data_reg <= rd_mux;  // [RULE_22]
      end else begin
        rd_data_reg <= `RXOM_ZERO8;
      end
    end
  end

  assign rd_data_o = rd_data_reg;

endmodule // rxom_overhead_monitor

`default_nettype wire

//--- verif/rxom_line_model.sv
`timescale 1ns/1ps
`default_nettype none
// *************************************************
// far-end line terminal: serial overhead streams
// *************************************************
module rxom_line_model (
  input  wire logic       ref_clk_i,
  output logic            fea_o,
  output logic            feb_o,
  output logic            mb_o,
  output logic            mv_o,
  output logic            ml_o,
  output logic            db_o,
  output logic            dv_o,
  output logic            de_o,
  output logic [7:0]      tb_o,
  output logic            tv_o,
  output logic            ta_o,
  output logic [3:0]      tf_o
);
  initial begin
    {fea_o, feb_o, mb_o, mv_o, ml_o, db_o, dv_o, de_o, tv_o, ta_o} = 10'h000;
    tb_o = 8'h00;
    tf_o = 4'h0;
  end
  // one error report per cycle while held
  task errs(input logic b, input int n);
    @(posedge ref_clk_i);
    fea_o <= !b;
    feb_o <= b;
    repeat (n) @(posedge ref_clk_i);
    fea_o <= 1'b0;
    feb_o <= 1'b0;
  endtask
  task mon(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      @(posedge ref_clk_i);
      mv_o <= 1'b1;
      mb_o <= v[i];
      ml_o <= (i == 0);
    end
    @(posedge ref_clk_i);
    mv_o <= 1'b0;
    ml_o <= 1'b0;
    mb_o <= !v[0];
  endtask
  // earliest bit is the code lsb
  task dl(input logic [23:0] v, input int n, input logic mf);
    for (int i = 0; i < n; i++) begin
      @(posedge ref_clk_i);
      dv_o <= 1'b1;
      db_o <= v[i];
      de_o <= mf && (i == n - 1);
    end
    @(posedge ref_clk_i);
    dv_o <= 1'b0;
    de_o <= 1'b0;
    db_o <= !db_o;
  endtask
  task ts0(input logic [7:0] v, input logic al, input logic [3:0] f);
    @(posedge ref_clk_i);
    tv_o <= 1'b1;
    tb_o <= v;
    ta_o <= al;
    tf_o <= f;
    @(posedge ref_clk_i);
    tv_o <= 1'b0;
    tb_o <= ~v;
  endtask
endmodule // rxom_line_model
`default_nettype wire

//--- verif/rxom_overhead_monitor_props.sv
`timescale 1ns/1ps
`default_nettype none
// *************************************************
// port-level checks of the monitor registers
// *************************************************
module rxom_overhead_monitor_props #(
  parameter [4:0] PORT_NUM = 5'd1
) (
  input wire logic        ref_clk_i,
  input wire logic        reset_i,
  input wire logic        ce_i,
  input wire logic [13:0] addr_i,
  input wire logic [7:0]  wr_data_i,
  input wire logic        wr_en_i,
  input wire logic        rd_en_i,
  input wire logic [7:0]  rd_data_o,
  input wire logic        rx_sync_lost_i,
  input wire logic        dl_mf_end_i,
  input wire logic [5:0]  boc_code_i,
  input wire logic        boc_code_vld_i,
  input wire logic [7:0]  ts0_byte_i,
  input wire logic        ts0_vld_i,
  input wire logic        ts0_align_i,
  input wire logic        crc_search_i,
  input wire logic        cas_search_i,
  input wire logic        fas_search_i
);
  localparam [13:0] BASE = 14'h0200 * (PORT_NUM - 1)
                         + 14'h2000 * ((PORT_NUM - 1) / 8);
  wire       hit = addr_i[13:9] == BASE[13:9];
  wire       rd_ok = ce_i && rd_en_i && hit;
  wire       rd_062 = rd_ok && addr_i[8:0] == 9'h062;
  wire       rd_063 = rd_ok && addr_i[8:0] == 9'h063;
  wire       rd_064 = rd_ok && addr_i[8:0] == 9'h064;
  wire       rd_065 = rd_ok && addr_i[8:0] == 9'h065;
  reg  [3:0] ctrl_reg;
  // mirror of the mode register, needed to know which map applies
  always @(posedge ref_clk_i or posedge reset_i) begin
    if (reset_i)
      ctrl_reg <= 4'h0;
    else if (ce_i && wr_en_i && hit && addr_i[8:0] == 9'h07F)
      ctrl_reg <= wr_data_i[3:0];
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  sequence s_align;
    ce_i && ts0_vld_i && ts0_align_i && ctrl_reg[0] && !rx_sync_lost_i
      ##1 !ts0_vld_i ##1 rd_064;
  endsequence
  sequence s_nonalign;
    ce_i && ts0_vld_i && !ts0_align_i && ctrl_reg[0] && !rx_sync_lost_i
      ##1 !ts0_vld_i ##1 rd_065;
  endsequence
  sequence s_boc;
    ce_i && boc_code_vld_i && !ctrl_reg[0] && !rx_sync_lost_i
      ##1 !boc_code_vld_i ##1 rd_063;
  endsequence
  sequence s_d4;
    ce_i && dl_mf_end_i && ctrl_reg[1:0] == 2'h2 && !rx_sync_lost_i
      ##1 !dl_mf_end_i ##1 rd_062;
  endsequence
  sequence s_frz;
    rx_sync_lost_i && rd_064 ##1 rx_sync_lost_i && !wr_en_i ##1 rd_064;
  endsequence
  property p_outside; ce_i && rd_en_i && !hit |=> rd_data_o == 8'h00;
  endproperty
  property p_crc_hunt;
    rd_062 && ctrl_reg[0] |=> rd_data_o[2] == $past(crc_search_i);
  endproperty
  property p_cas_fas;
    rd_062 && ctrl_reg[0] |=>
      rd_data_o[1:0] == $past({cas_search_i, fas_search_i});
  endproperty
  property p_csc_off;
    rd_062 && ctrl_reg[0] && !ctrl_reg[3] |=> rd_data_o[7:3] == 5'h00;
  endproperty
  property p_align; s_align |=> rd_data_o == $past(ts0_byte_i, 3);
  endproperty
  property p_nonalign; s_nonalign |=> rd_data_o == $past(ts0_byte_i, 3);
  endproperty
  property p_boc; s_boc |=> rd_data_o == {2'h0, $past(boc_code_i, 3)};
  endproperty
  property p_d4; s_d4 |=> rd_data_o[7:6] == 2'h0;
  endproperty
  property p_frz; s_frz |=> rd_data_o == $past(rd_data_o, 2);
  endproperty
  a_outside: assert property (p_outside)
    else $error("read outside the port window returned data");
  a_crc_hunt: assert property (p_crc_hunt)
    else $error("multiframe hunt bit wrong");
  a_cas_fas: assert property (p_cas_fas)
    else $error("signaling or frame hunt bits wrong");
  a_csc_off: assert property (p_csc_off)
    else $error("sync count not zero with crc disabled");
  a_align: assert property (p_align)
    else $error("align frame byte not captured");
  a_nonalign: assert property (p_nonalign)
    else $error("non-align frame byte not captured");
  a_boc: assert property (p_boc)
    else $error("bit-oriented code not captured");
  a_d4: assert property (p_d4)
    else $error("superframe data link top bits not zero");
  a_frz: assert property (p_frz)
    else $error("capture changed while out of frame");
endmodule // rxom_overhead_monitor_props
bind rxom_overhead_monitor rxom_overhead_monitor_props #(.PORT_NUM(PORT_NUM))
  i_rxom_overhead_monitor_props (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
  .ce_i(ce_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_en_i(wr_en_i),
  .rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .rx_sync_lost_i(rx_sync_lost_i),
  .dl_mf_end_i(dl_mf_end_i), .boc_code_i(boc_code_i),
  .boc_code_vld_i(boc_code_vld_i), .ts0_byte_i(ts0_byte_i),
  .ts0_vld_i(ts0_vld_i), .ts0_align_i(ts0_align_i),
  .crc_search_i(crc_search_i), .cas_search_i(cas_search_i),
  .fas_search_i(fas_search_i));
`default_nettype wire

//--- verif/rxom_overhead_monitor_tb.sv
`timescale 1ns/1ps
`default_nettype none
// *************************************************
// register-level tests of port 11
// *************************************************
module rxom_overhead_monitor_tb;
  localparam [4:0]  PN = 5'd11;
  localparam [13:0] BASE = 14'h0200 * (PN - 1) + 14'h2000 * ((PN - 1) / 8);
  logic        ref_clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic        ce_i = 1'b1;
  logic [13:0] addr_i = 14'h0000;
  logic [7:0]  wr_data_i = 8'h00;
  logic        wr_en_i = 1'b0;
  logic        rd_en_i = 1'b0;
  logic        rx_sync_lost_i = 1'b0;
  logic [5:0]  boc_code_i = 6'h00;
  logic        boc_code_vld_i = 1'b0;
  logic        crc_search_timeout_i = 1'b0;
  logic        crc_sync_gained_i = 1'b0;
  logic [2:0]  srch = 3'h0;
  wire  [7:0]  rd_data_o;
  wire         fea, feb, mb, mv, ml, db, dv, de, tv, ta;
  wire  [7:0]  tb;
  wire  [3:0]  tf;
  int          fails = 0;
  int          n_tests = 0;
  logic [8:0] i_ofs [10] = '{9'h058, 9'h059, 9'h05A, 9'h05B, 9'h060,
                             9'h062, 9'h063, 9'h064, 9'h065, 9'h066};
  always #4 ref_clk_i = ~ref_clk_i;
  rxom_overhead_monitor #(.PORT_NUM(PN)) i_rxom_overhead_monitor (
    .ref_clk_i(ref_clk_i), .reset_i(reset_i), .ce_i(ce_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
    .rd_data_o(rd_data_o), .rx_sync_lost_i(rx_sync_lost_i),
    .fe_err_a_evt_i(fea), .fe_err_b_evt_i(feb), .mon_bit_i(mb),
    .mon_bit_vld_i(mv), .mon_bit_last_i(ml), .dl_bit_i(db),
    .dl_bit_vld_i(dv), .dl_mf_end_i(de), .boc_code_i(boc_code_i),
    .boc_code_vld_i(boc_code_vld_i), .ts0_byte_i(tb), .ts0_vld_i(tv),
    .ts0_align_i(ta), .ts0_frame_i(tf),
    .crc_search_timeout_i(crc_search_timeout_i),
    .crc_sync_gained_i(crc_sync_gained_i), .crc_search_i(srch[2]),
    .cas_search_i(srch[1]), .fas_search_i(srch[0]));
  rxom_line_model i_rxom_line_model (.ref_clk_i(ref_clk_i), .fea_o(fea),
    .feb_o(feb), .mb_o(mb), .mv_o(mv), .ml_o(ml), .db_o(db), .dv_o(dv),
    .de_o(de), .tb_o(tb), .tv_o(tv), .ta_o(ta), .tf_o(tf));
  task results;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task wr(input logic [8:0] o, input logic [7:0] d);
    @(posedge ref_clk_i);
    wr_en_i <= 1'b1;
    addr_i <= BASE + {5'h00, o};
    wr_data_i <= d;
    @(posedge ref_clk_i);
    wr_en_i <= 1'b0;
  endtask
  task rda(input logic [13:0] a, input logic [7:0] exp);
    @(posedge ref_clk_i);
    rd_en_i <= 1'b1;
    addr_i <= a;
    @(posedge ref_clk_i);
    rd_en_i <= 1'b0;
    #1;
    n_tests++;
    if (rd_data_o !== exp) begin
      fails++;
      $display("BAD at %0t: got %h expected %h", $time, rd_data_o, exp);
    end
  endtask
  task rd(input logic [8:0] o, input logic [7:0] exp);
    rda(BASE + {5'h00, o}, exp);
  endtask
  task tmo(input int n);
    @(posedge ref_clk_i);
    crc_search_timeout_i <= 1'b1;
    repeat (n) @(posedge ref_clk_i);
    crc_search_timeout_i <= 1'b0;
  endtask
  initial begin
    #200000;
    fails++;
    results;
  end
  initial begin
    repeat (20) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    foreach (i_ofs[k]) rd(i_ofs[k], 8'h00);
    i_rxom_line_model.errs(1'b0, 257);
    rd(9'h058, 8'h01);
    rd(9'h059, 8'h01);
    rd(9'h059, 8'h01);
    // errors arriving while the enable is low must not be counted
    ce_i <= 1'b0;
    i_rxom_line_model.errs(1'b0, 3);
    ce_i <= 1'b1;
    rd(9'h059, 8'h01);
    i_rxom_line_model.errs(1'b1, 2);
    rd(9'h05A, 8'h00);
    rd(9'h05B, 8'h02);
    i_rxom_line_model.mon(8'hA5);
    rd(9'h060, 8'hA5);
    i_rxom_line_model.dl(24'h00003C, 8, 1'b0);
    rd(9'h062, 8'h3C);
    @(posedge ref_clk_i);
    boc_code_i <= 6'h2A;
    boc_code_vld_i <= 1'b1;
    @(posedge ref_clk_i);
    boc_code_vld_i <= 1'b0;
    boc_code_i <= 6'h15;
    rd(9'h063, 8'h2A);
    wr(9'h07F, 8'h02);
    i_rxom_line_model.dl(24'h000005, 3, 1'b0);
    rd(9'h062, 8'h3C);
    i_rxom_line_model.dl(24'h000015, 6, 1'b1);
    rd(9'h062, 8'h15);
    wr(9'h07F, 8'h06);
    i_rxom_line_model.dl(24'hC35A96, 24, 1'b1);
    rd(9'h064, 8'h96);
    rd(9'h065, 8'h5A);
    rd(9'h066, 8'hC3);
    // second reset so the E1 captures start from a clean slate
    @(posedge ref_clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    wr(9'h07F, 8'h01);
    @(posedge ref_clk_i);
    srch <= 3'b101;
    rd(9'h062, 8'h05);
    @(posedge ref_clk_i);
    srch <= 3'b010;
    rd(9'h062, 8'h02);
    wr(9'h07F, 8'h09);
    tmo(5);
    rd(9'h062, 8'h1A);
    tmo(70);
    rd(9'h062, 8'hFA);
    @(posedge ref_clk_i);
    crc_sync_gained_i <= 1'b1;
    @(posedge ref_clk_i);
    crc_sync_gained_i <= 1'b0;
    srch <= 3'b000;
    rd(9'h062, 8'h00);
    tmo(2);
    rd(9'h062, 8'h00);
    tmo(1);
    rd(9'h062, 8'h08);
    wr(9'h07F, 8'h01);
    rd(9'h062, 8'h00);
    i_rxom_line_model.ts0(8'h9B, 1'b1, 4'h0);
    rd(9'h064, 8'h9B);
    rd(9'h066, 8'h01);
    i_rxom_line_model.ts0(8'h9B, 1'b1, 4'hE);
    rd(9'h066, 8'h81);
    i_rxom_line_model.ts0(8'hD5, 1'b0, 4'h1);
    rd(9'h065, 8'hD5);
    @(posedge ref_clk_i);
    rx_sync_lost_i <= 1'b1;
    i_rxom_line_model.ts0(8'h1B, 1'b1, 4'h0);
    rd(9'h064, 8'h9B);
    rd(9'h064, 8'h9B);
    rd(9'h066, 8'h81);
    rx_sync_lost_i <= 1'b0;
    rda(BASE - 14'h0200 + 14'h0064, 8'h00);
    rd(9'h061, 8'h00);
    wr(9'h064, 8'hFF);
    rd(9'h064, 8'h9B);
    results;
  end
endmodule // rxom_overhead_monitor_tb
`default_nettype wire
